// file: shared/cmov_signed_mul_subtract_pkg.sv
// Shared encodings, field positions and state layout for the conditional move
// and multiply-subtract execute block.
// Assumes a 32-bit instruction word and 32-bit general registers.
package cmov_signed_mul_subtract_pkg;

   // Major opcodes
   localparam logic [5:0] base_opcode = 6'h00;
   localparam logic [5:0] fpu_major_opcode = 6'h11;
   localparam logic [5:0] second_special_opcode = 6'h1c;

   // Function codes
   localparam logic [5:0] flag_move_function = 6'h01;
   localparam logic [5:0] move_if_zero_function = 6'h0a;
   localparam logic [5:0] fp_flag_move_function = 6'h11;
   localparam logic [5:0] fp_move_if_zero_function = 6'h12;
   localparam logic [5:0] fp_move_if_nonzero_function = 6'h13;
   localparam logic [5:0] signed_mul_subtract_function = 6'h04;
   localparam logic [5:0] unsigned_mul_subtract_function = 6'h05;

   // Format field codes
   localparam logic [4:0] fmt_single = 5'h10;
   localparam logic [4:0] fmt_double = 5'h11;

   // Field positions (low bit of each field)
   localparam int opcode_lsb = 26;
   localparam int operand_a_lsb = 21;
   localparam int fmt_lsb = 21;
   localparam int operand_b_lsb = 16;
   localparam int fp_flag_select_lsb = 18;
   localparam int flag_zero_bit = 17;
   localparam int true_false_bit = 16;
   localparam int result_lsb = 11;
   localparam int fp_source_lsb = 11;
   localparam int fp_dest_lsb = 6;
   localparam int shift_field_lsb = 6;

   // An operand b of this width or less takes the short multiply path
   localparam int short_operand_bits = 16;

   typedef enum logic [0:0] {
      mul_idle = 1'b0,
      mul_tail = 1'b1
   } mul_state_t;

   typedef struct packed {
      mul_state_t mul;
      logic gpr_we;
      logic [4:0] gpr_idx;
      logic [31:0] gpr_data;
      logic fpr_we;
      logic fpr_double;
      logic [4:0] fpr_idx;
      logic [63:0] fpr_data;
      logic pair_we;
      logic [31:0] pair_upper;
      logic [31:0] pair_bottom;
      logic [63:0] held_pair;
      logic [63:0] held_product;
      logic exc_reserved;
      logic exc_unusable;
      logic exc_unimplemented;
   } unit_state_t;

   localparam unit_state_t unit_reset = '{
      mul: mul_idle,
      gpr_we: 1'b0,
      gpr_idx: 5'h00,
      gpr_data: 32'h0000_0000,
      fpr_we: 1'b0,
      fpr_double: 1'b0,
      fpr_idx: 5'h00,
      fpr_data: 64'h0000_0000_0000_0000,
      pair_we: 1'b0,
      pair_upper: 32'h0000_0000,
      pair_bottom: 32'h0000_0000,
      held_pair: 64'h0000_0000_0000_0000,
      held_product: 64'h0000_0000_0000_0000,
      exc_reserved: 1'b0,
      exc_unusable: 1'b0,
      exc_unimplemented: 1'b0
   };

endpackage

// file: logic/cond_move_mul_subtract.sv
// Execute logic for conditional moves and multiply-subtract.
// Assumes the pipeline forwards the newest operand, flag and product pair
// values onto the inputs and commits the registered write ports.
`timescale 1ns/1ps
`default_nettype none

module cond_move_mul_subtract
   import cmov_signed_mul_subtract_pkg::*;
#(
   parameter bit HAS_DOUBLE = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic issue_valid,
   output logic issue_ready,
   input wire logic [31:0] instr,
   input wire logic [31:0] operand_a_value,
   input wire logic [31:0] operand_b_value,
   input wire logic [63:0] fp_source_value,
   input wire logic [7:0] fp_flags,
   input wire logic [31:0] pair_upper_in,
   input wire logic [31:0] pair_bottom_in,
   input wire logic fpu_usable,
   output logic claimed,
   output logic gpr_we,
   output logic [4:0] gpr_idx,
   output logic [31:0] gpr_data,
   output logic fpr_we,
   output logic fpr_double,
   output logic [4:0] fpr_idx,
   output logic [63:0] fpr_data,
   output logic product_we,
   output logic [31:0] product_upper_word,
   output logic [31:0] product_bottom_word,
   output logic exc_reserved,
   output logic exc_unusable,
   output logic exc_unimplemented,
   output logic [4:0] ieee_flags
);

   unit_state_t cur;
   unit_state_t next_cur;

   function automatic logic [4:0] field5(input logic [31:0] word, input int lsb);
      field5 = word[lsb +: 5];
   endfunction

   function automatic logic [63:0] product(input logic [31:0] a, input logic [31:0] b, input logic signed_op);
      logic [63:0] ext_a;
      logic [63:0] ext_b;
      ext_a = signed_op ? {{32{a[31]}}, a} : {32'h0000_0000, a};
      ext_b = signed_op ? {{32{b[31]}}, b} : {32'h0000_0000, b};
      product = ext_a * ext_b;
   endfunction

   logic [5:0] opcode;
   logic [5:0] func;
   logic [4:0] fmt;
   logic shift_zero;
   logic rd_zero;
   logic is_flag_move;
   logic is_move_zero;
   logic is_fp_flag_move;
   logic is_fp_zero;
   logic is_fp_nonzero;
   logic is_fp_move;
   logic is_signed_mul_subtract;
   logic signed_op;
   logic selected_flag;
   logic b_is_zero;
   logic fmt_valid;
   logic short_b;
   logic [63:0] prod_now;
   logic [63:0] pair_now;
   logic [63:0] diff_now;
   logic [63:0] diff_tail;
   logic take;

   assign opcode = instr[opcode_lsb +: 6];
   assign func = instr[5:0];
   assign fmt = field5(instr, fmt_lsb);
   assign shift_zero = field5(instr, shift_field_lsb) == 5'h00;
   assign rd_zero = field5(instr, result_lsb) == 5'h00;
   assign selected_flag = fp_flags[instr[fp_flag_select_lsb +: 3]];
   assign b_is_zero = operand_b_value == 32'h0000_0000;
   assign fmt_valid = fmt == fmt_single || fmt == fmt_double;

   // Only the true-select form of the flag move belongs here
   assign is_flag_move = opcode == base_opcode && func == flag_move_function && instr[true_false_bit];
   // Malformed shift field is not this instruction, so no fault is ever raised
   assign is_move_zero = opcode == base_opcode && func == move_if_zero_function && shift_zero;
   assign is_fp_flag_move = opcode == fpu_major_opcode && func == fp_flag_move_function && instr[true_false_bit];
   assign is_fp_zero = opcode == fpu_major_opcode && func == fp_move_if_zero_function;
   assign is_fp_nonzero = opcode == fpu_major_opcode && func == fp_move_if_nonzero_function;
   assign is_fp_move = is_fp_flag_move || is_fp_zero || is_fp_nonzero;
   assign is_signed_mul_subtract = opcode == second_special_opcode && shift_zero && rd_zero
      && (func == signed_mul_subtract_function || func == unsigned_mul_subtract_function);
   assign signed_op = func == signed_mul_subtract_function;

   // Short operand b: upper bits are a pure extension of the short field
   assign short_b = signed_op
      ? (operand_b_value[31:short_operand_bits-1] == '0 || operand_b_value[31:short_operand_bits-1] == '1)
      : operand_b_value[31:short_operand_bits] == '0;

   assign prod_now = product(operand_a_value, operand_b_value, signed_op);
   assign pair_now = {pair_upper_in, pair_bottom_in};
   // Plain modular subtraction: wraparound is silent, no fault path exists
   assign diff_now = pair_now - prod_now;
   assign diff_tail = cur.held_pair - cur.held_product;

   assign issue_ready = cur.mul == mul_idle;
   assign take = issue_valid && issue_ready;
   assign claimed = issue_valid && (is_flag_move || is_move_zero || is_fp_move || is_signed_mul_subtract);

   always_comb begin
      next_cur = cur;
      next_cur.gpr_we = 1'b0;
      next_cur.fpr_we = 1'b0;
      next_cur.pair_we = 1'b0;
      next_cur.exc_reserved = 1'b0;
      next_cur.exc_unusable = 1'b0;
      next_cur.exc_unimplemented = 1'b0;
      unique case (cur.mul)
         mul_idle: begin
            if (take && is_flag_move) begin
               next_cur.gpr_idx = field5(instr, result_lsb);
               next_cur.gpr_data = operand_a_value;
               if (!fpu_usable) begin
                  next_cur.exc_unusable = 1'b1;
               end else if (instr[flag_zero_bit] || !shift_zero) begin
                  next_cur.exc_reserved = 1'b1;
               end else begin
                  next_cur.gpr_we = selected_flag;
               end
            end
            if (take && is_move_zero) begin
               next_cur.gpr_idx = field5(instr, result_lsb);
               next_cur.gpr_data = operand_a_value;
               next_cur.gpr_we = b_is_zero;
            end
            if (take && is_fp_move) begin
               next_cur.fpr_idx = field5(instr, fp_dest_lsb);
               next_cur.fpr_double = fmt == fmt_double;
               next_cur.fpr_data = fp_source_value;
               if (!fpu_usable) begin
                  next_cur.exc_unusable = 1'b1;
               end else if (!fmt_valid || (is_fp_flag_move && instr[flag_zero_bit])) begin
                  next_cur.exc_reserved = 1'b1;
               end else if (fmt == fmt_double && !HAS_DOUBLE) begin
                  next_cur.exc_unimplemented = 1'b1;
               end else begin
                  // A false test leaves the destination alone, never reformats it
                  next_cur.fpr_we = (is_fp_flag_move && selected_flag)
                     || (is_fp_zero && b_is_zero)
                     || (is_fp_nonzero && !b_is_zero);
               end
            end
            if (take && is_signed_mul_subtract) begin
               if (short_b) begin
                  next_cur.pair_we = 1'b1;
                  next_cur.pair_upper = diff_now[63:32];
                  next_cur.pair_bottom = diff_now[31:0];
               end else begin
                  // Long operand: spend a cycle so the wide product is registered
                  next_cur.mul = mul_tail;
                  next_cur.held_pair = pair_now;
                  next_cur.held_product = prod_now;
               end
            end
         end
         mul_tail: begin
            next_cur.mul = mul_idle;
            next_cur.pair_we = 1'b1;
            next_cur.pair_upper = diff_tail[63:32];
            next_cur.pair_bottom = diff_tail[31:0];
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur <= unit_reset;
      end else begin
         cur <= next_cur;
      end
   end

   assign gpr_we = cur.gpr_we;
   assign gpr_idx = cur.gpr_idx;
   assign gpr_data = cur.gpr_data;
   assign fpr_we = cur.fpr_we;
   assign fpr_double = cur.fpr_double;
   assign fpr_idx = cur.fpr_idx;
   assign fpr_data = cur.fpr_data;
   assign product_we = cur.pair_we;
   assign product_upper_word = cur.pair_upper;
   assign product_bottom_word = cur.pair_bottom;
   assign exc_reserved = cur.exc_reserved;
   assign exc_unusable = cur.exc_unusable;
   assign exc_unimplemented = cur.exc_unimplemented;
   assign ieee_flags = 5'h00;

endmodule

`default_nettype wire

// file: sim/cmov_signed_mul_subtract_asserts.sv
// Checker for the conditional move and multiply-subtract block.
// Sees only the top ports; bound to every instance below.
`timescale 1ns/1ps
`default_nettype none
module cmov_signed_mul_subtract_asserts
   import cmov_signed_mul_subtract_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic issue_ready,
   input wire logic [31:0] instr,
   input wire logic [31:0] operand_a_value,
   input wire logic [31:0] operand_b_value,
   input wire logic [7:0] fp_flags,
   input wire logic fpu_usable,
   input wire logic claimed,
   input wire logic gpr_we,
   input wire logic [31:0] gpr_data,
   input wire logic fpr_we,
   input wire logic product_we,
   input wire logic exc_reserved,
   input wire logic exc_unusable,
   input wire logic [4:0] ieee_flags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire take = claimed && issue_ready;
   wire move_if_zero = take && instr[31:26] == base_opcode && instr[5:0] == move_if_zero_function;
   wire flagmv = take && instr[31:26] == base_opcode && instr[5:0] == flag_move_function;
   wire signed_mul_subtract = take && instr[31:26] == second_special_opcode;
   wire sel = fp_flags[instr[20:18]];
   a_zero_move_write: assert property (move_if_zero && operand_b_value == 32'h0000_0000 |=>
      gpr_we && gpr_data == $past(operand_a_value)) else $error("zero move lost");
   a_zero_move_skip: assert property (move_if_zero && operand_b_value != 32'h0000_0000 |=> !gpr_we)
      else $error("zero move wrote");
   a_flag_true_move: assert property (flagmv && fpu_usable && instr[17:16] == 2'b01 && instr[10:6] == 5'h00
      |=> gpr_we == $past(sel)) else $error("flag move wrong");
   a_unusable_no_write: assert property (flagmv && !fpu_usable |=> exc_unusable && !gpr_we)
      else $error("unusable fault missing");
   a_fault_no_write: assert property (exc_reserved || exc_unusable |-> !gpr_we && !fpr_we)
      else $error("write beside fault");
   a_signed_mul_subtract_no_gpr: assert property (signed_mul_subtract |=> !gpr_we && !exc_reserved && !exc_unusable)
      else $error("multiply wrote register");
   a_tail_one_cycle: assert property (!issue_ready |-> $past(signed_mul_subtract) ##1 issue_ready)
      else $error("bad tail cycle");
   a_signed_mul_subtract_answer: assert property (signed_mul_subtract |-> ##[1:2] product_we)
      else $error("pair write late");
   a_ieee_quiet: assert property (ieee_flags == 5'h00)
      else $error("ieee flag raised");
   c_long_signed_mul_subtract: cover property (signed_mul_subtract ##1 !issue_ready);
   c_fp_write: cover property (fpr_we);
   c_fault: cover property (exc_unusable);
endmodule
bind cond_move_mul_subtract cmov_signed_mul_subtract_asserts u_cmov_signed_mul_subtract_asserts (.clk, .resetn, .issue_ready, .instr,
   .operand_a_value, .operand_b_value, .fp_flags, .fpu_usable, .claimed, .gpr_we, .gpr_data, .fpr_we,
   .product_we, .exc_reserved, .exc_unusable, .ieee_flags);
`default_nettype wire

// file: sim/pipeline_model.sv
// Pipeline side: holds the product pair the block reads back.
// Commits registered pair writes; clears the pair on reset.
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic product_we,
   input wire logic [31:0] product_upper_word,
   input wire logic [31:0] product_bottom_word,
   output logic [31:0] pair_upper_in,
   output logic [31:0] pair_bottom_in
);
   logic [63:0] pair;
   // Forwarding keeps a back-to-back multiply on the newest pair
   assign {pair_upper_in, pair_bottom_in} = product_we ? {product_upper_word, product_bottom_word} : pair;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pair <= 64'h0000_0000_0000_0000;
      end else if (product_we) begin
         pair <= {product_upper_word, product_bottom_word};
      end
   end
endmodule
`default_nettype wire

// file: sim/cond_move_mul_subtract_bench.sv
// Bench for the conditional move and multiply-subtract block.
// Drives inputs on the falling edge; the pipeline model feeds the pair back.
`timescale 1ns/1ps
`default_nettype none
module cond_move_mul_subtract_bench;
   import cmov_signed_mul_subtract_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, issue_valid = 1'b0, fpu_usable = 1'b1;
   logic [31:0] instr = 32'h0000_0000, operand_a_value = 32'h0000_0000, operand_b_value = 32'h0000_0000;
   logic [63:0] fp_source_value = 64'h0000_0000_0000_0000, pair_exp = 64'h0000_0000_0000_0000, fpr_data;
   logic [7:0] fp_flags = 8'h00;
   logic issue_ready, claimed, gpr_we, fpr_we, fpr_double, product_we, exc_reserved, exc_unusable, exc_unimplemented;
   logic [4:0] gpr_idx, fpr_idx, ieee_flags;
   logic [31:0] gpr_data, product_upper_word, product_bottom_word, pair_upper_in, pair_bottom_in;
   int n_fail = 0, comparisons = 0, cycles = 0;
   cond_move_mul_subtract u_cond_move_mul_subtract (.clk, .resetn, .issue_valid, .issue_ready, .instr,
      .operand_a_value, .operand_b_value, .fp_source_value, .fp_flags, .pair_upper_in, .pair_bottom_in,
      .fpu_usable, .claimed, .gpr_we, .gpr_idx, .gpr_data, .fpr_we, .fpr_double, .fpr_idx, .fpr_data,
      .product_we, .product_upper_word, .product_bottom_word, .exc_reserved, .exc_unusable,
      .exc_unimplemented, .ieee_flags);
   pipeline_model u_pipeline_model (.clk, .resetn, .product_we, .product_upper_word, .product_bottom_word,
      .pair_upper_in, .pair_bottom_in);
   always #4 clk = ~clk;
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Hang guard well beyond the few dozen cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         complete_run;
      end
   end
   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Entered at a falling edge; returns at the falling edge after acceptance
   task automatic issue(input logic [31:0] word);
      int n;
      n = 0;
      instr = word;
      issue_valid = 1'b1;
      while (issue_ready !== 1'b1 && n < 4) begin
         n++;
         @(negedge clk);
      end
      // A block that never takes the issue is a failure, not a silent skip
      if (n == 4) begin
         n_fail++;
      end
      @(negedge clk);
   endtask
   task automatic idle;
      issue_valid = 1'b0;
      @(negedge clk);
   endtask
   task automatic t_move_zero;
      operand_a_value = 32'hcafe_0001;
      issue({base_opcode, 5'h03, 5'h04, 5'h09, 5'h00, move_if_zero_function});
      chk({gpr_we, gpr_idx, gpr_data}, {1'b1, 5'h09, 32'hcafe_0001});
      operand_b_value = 32'h0000_0100;
      issue({base_opcode, 5'h03, 5'h04, 5'h09, 5'h00, move_if_zero_function});
      chk(gpr_we, 1'b0);
   endtask
   task automatic t_flag_true;
      fp_flags = 8'h96;
      for (int c = 0; c < 8; c++) begin
         issue({base_opcode, 5'h02, c[2:0], 2'b01, 5'h07, 5'h00, flag_move_function});
         chk(gpr_we, fp_flags[c]);
      end
      issue({base_opcode, 5'h02, 3'h1, 2'b11, 5'h07, 5'h00, flag_move_function});
      chk({exc_reserved, gpr_we}, 2'b10);
      fpu_usable = 1'b0;
      issue({base_opcode, 5'h02, 3'h1, 2'b01, 5'h07, 5'h00, flag_move_function});
      chk({exc_unusable, gpr_we}, 2'b10);
      fpu_usable = 1'b1;
   endtask
   task automatic t_fp_moves;
      logic [5:0] fn [3] = '{fp_flag_move_function, fp_move_if_zero_function, fp_move_if_nonzero_function};
      logic hit, dbl;
      for (int k = 0; k < 12; k++) begin
         hit = k >= 6;
         dbl = 1'((k / 3) % 2);
         fp_flags = hit ? 8'h04 : 8'hfb;
         operand_b_value = (hit == (k % 3 == 2)) ? 32'h0000_0040 : 32'h0000_0000;
         fp_source_value = 64'h1234_5678_9abc_0000 + 64'(k);
         issue({fpu_major_opcode, dbl ? fmt_double : fmt_single, k % 3 == 0 ? 5'h09 : 5'h05, 5'h0c, 5'h0e, fn[k % 3]});
         chk({fpr_we, exc_unimplemented, ieee_flags}, {hit, 1'b0, 5'h00});
         if (hit) begin
            chk({fpr_double, fpr_idx, fpr_data}, {dbl, 5'h0e, fp_source_value});
         end
      end
      issue({fpu_major_opcode, 5'h14, 5'h05, 5'h0c, 5'h0e, fp_move_if_zero_function});
      chk({exc_reserved, fpr_we}, 2'b10);
      fpu_usable = 1'b0;
      issue({fpu_major_opcode, fmt_single, 5'h05, 5'h0c, 5'h0e, fp_move_if_zero_function});
      chk({exc_unusable, exc_reserved, fpr_we}, 3'b100);
      fpu_usable = 1'b1;
   endtask
   task automatic do_signed_mul_subtract(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] b, input int lat);
      if (fn == unsigned_mul_subtract_function) begin
         pair_exp = pair_exp - {32'h0000_0000, a} * {32'h0000_0000, b};
      end else begin
         pair_exp = pair_exp - {{32{a[31]}}, a} * {{32{b[31]}}, b};
      end
      operand_a_value = a;
      operand_b_value = b;
      issue({second_special_opcode, 5'h05, 5'h06, 10'h000, fn});
      if (lat == 2) begin
         chk({issue_ready, product_we, claimed}, 3'b001);
         idle;
      end
      chk({product_we, product_upper_word, product_bottom_word}, {1'b1, pair_exp});
      chk({gpr_we, exc_reserved, exc_unusable}, 3'b000);
   endtask
   task automatic t_signed_mul_subtract;
      do_signed_mul_subtract(signed_mul_subtract_function, 32'h0000_0003, 32'hffff_fffe, 1);
      do_signed_mul_subtract(unsigned_mul_subtract_function, 32'hffff_ffff, 32'h0000_0002, 1);
      do_signed_mul_subtract(unsigned_mul_subtract_function, 32'hffff_ffff, 32'h0001_0000, 2);
      do_signed_mul_subtract(signed_mul_subtract_function, 32'h8000_0000, 32'h8000_0000, 2);
      instr = {second_special_opcode, 5'h05, 5'h06, 5'h01, 5'h00, signed_mul_subtract_function};
      issue_valid = 1'b1;
      @(negedge clk);
      chk({claimed, product_we}, 2'b00);
      idle;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      t_move_zero;
      t_flag_true;
      t_fp_moves;
      t_signed_mul_subtract;
      complete_run;
   end
endmodule
`default_nettype wire
